// ### zone_input_consts.vh
`ifndef ZONE_INPUT_CONSTS_VH
`define ZONE_INPUT_CONSTS_VH

// Register indices on the module register port
`define OFS_STOP_STATUS     8'h13
`define OFS_SENSOR_BITS     8'h23
`define OFS_UP_REL_ECHO     8'h69
`define OFS_REV_TAG_LO      8'h79
`define OFS_REV_TAG_HI      8'h7A
`define OFS_DN_REL_ECHO     8'hB9
`define OFS_DN_HELD_TAG_HI  8'hC8
`define OFS_FWD_TAG_LO      8'hC9
`define OFS_FWD_TAG_HI      8'hCA

// Sensor register field positions
`define SNS_LEFT_AUX        0
`define SNS_RIGHT_AUX       2
`define SNS_LEFT_SIG        4
`define SNS_RIGHT_SIG       6
`define SNS_HEARTBEAT       15

// Stop status field positions
`define STP_GROUP           5
`define STP_LINK_LOST       6
`define STP_CTRL_LOST       7
`define STP_CTRL_CMD        10

// Zone status encodings, low byte
`define ZS_MIN              8'h01
`define ZS_MAX              8'h06

// Reset values
`define RST_WORD            16'h0000

// Heartbeat half period: 2 s at 20 MHz (50 ns)
`define HB_HALF_MS          2000
`define CLK_NS              50
`define HB_HALF_CYC         ((`HB_HALF_MS * 1000000) / `CLK_NS)

`endif

// ### heartbeat_gen.v
`include "zone_input_consts.vh"

// Free running square wave, equal high and low halves
module heartbeat_gen #(
    parameter HALF_CYCLES = `HB_HALF_CYC // Cycles per half period
) (
    input wire clk,     // System clock
    input wire sys_rst, // Synchronous reset, active high
    output reg beat     // Heartbeat level
);

    reg [31:0] cnt_reg; // Cycles into the current half

    ////////////////////////////////////////////////////////////////////////
    // Count halves and flip the level
    always @(posedge clk) begin
        if (sys_rst) begin
            cnt_reg <= 32'h00000000;
            beat <= 1'b1;
        end else if (cnt_reg >= HALF_CYCLES - 1) begin
            // End of half: restart and toggle
            cnt_reg <= 32'h00000000;
            beat <= ~beat;
        end else begin
            cnt_reg <= cnt_reg + 32'h00000001;
        end
    end

endmodule

// ### zone_input_status_registers.v
`include "zone_input_consts.vh"

// Behaviour
// - Held downstream load shows tracking word two
// - Echo upstream release output register value
// - Echo downstream release output register value
// - Forward discharge latches both tracking words
// - Reverse discharge latches both tracking words
// - Sensor bits 0,2,4,6 map aux, signals
// - Bit 15 heartbeat two seconds each
// - Stop bit 5: group stop elsewhere
// - Stop bit 6: inter-module link lost
// - Stop bit 7: controller connection lost
// - Stop bit 10: controller stop command
// - Other stop bits reserved, read zero
// - Zone status low byte values 1-6
// - High byte may carry reversing status
// - Byte image places high byte first
// - Sensor bits read 1 when blocked
module zone_input_status_registers #(
    parameter HB_HALF = `HB_HALF_CYC // Heartbeat half period in cycles
) (
    input wire clk,                   // 20 MHz clock
    input wire sys_rst,               // Synchronous reset, active high
    input wire [7:0] reg_addr,        // Register index
    input wire reg_rd,                // Read strobe
    input wire reg_wr,                // Write strobe, only acknowledged
    input wire [15:0] reg_wdata,      // Write data, ignored
    output reg [15:0] reg_rdata,      // Read data word
    output reg reg_ack,               // Read or write answered
    input wire [3:0] img_byte_idx,    // Byte index into image words
    output reg [7:0] img_byte,        // Byte of the process image
    input wire dn_zone_held,          // Downstream load accumulated, stopped
    input wire [15:0] dn_tag_hi,      // Tracking word 2 of downstream load
    input wire [15:0] dn_tag_lo,      // Tracking word 1 of downstream load
    input wire [15:0] up_release_out, // Upstream release output register
    input wire [15:0] dn_release_out, // Downstream release output register
    input wire discharge_evt,         // Pulse: load left to plain conveyor
    input wire dir_reverse,           // Belt runs opposite default
    input wire left_aux_pin,          // Left aux input pin
    input wire right_aux_pin,         // Right aux input pin
    input wire left_sensor_pin,       // Left sensor pin
    input wire right_sensor_pin,      // Right sensor pin
    input wire left_sensor_inv,       // Left sensor light-on-clear polarity
    input wire right_sensor_inv,      // Right sensor light-on-clear polarity
    input wire stop_group,            // Stop active on group peer
    input wire stop_link_lost,        // Stop by lost inter-module link
    input wire stop_ctrl_lost,        // Stop by lost controller link
    input wire stop_ctrl_cmd,         // Stop by controller command
    input wire [2:0] zone_state,      // Zone logical state 1..6
    input wire [7:0] zone_rev_state,  // Reversing status, high byte
    output reg [15:0] zone_status     // Encoded zone status word
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    reg [3:0] pin_s1_reg;          // First sync stage, pins
    reg [3:0] pin_s2_reg;          // Second sync stage, pins
    reg [3:0] stp_s1_reg;          // First sync stage, stop causes
    reg [3:0] stp_s2_reg;          // Second sync stage, stop causes
    reg [15:0] held_hi_reg;        // Downstream held word 2
    reg [15:0] fwd_lo_reg;         // Forward discharge word 1
    reg [15:0] fwd_hi_reg;         // Forward discharge word 2
    reg [15:0] rev_lo_reg;         // Reverse discharge word 1
    reg [15:0] rev_hi_reg;         // Reverse discharge word 2
    reg [15:0] up_echo_reg;        // Upstream release echo
    reg [15:0] dn_echo_reg;        // Downstream release echo
    reg [15:0] sensor_reg;         // Sensor port input image
    reg [15:0] stop_reg;           // Stop status image
    reg [15:0] rdata_next;         // Read mux result
    reg [15:0] img_word;           // Word picked for byte image
    reg [7:0] zs_low;              // Clamped zone status low byte
    wire beat;                     // Heartbeat level

    ////////////////////////////////////////////////////////////////////////
    // Map a register index to its word
    function [15:0] pick_word;
        input [7:0] a;
        begin
            if (a == `OFS_STOP_STATUS) begin
                pick_word = stop_reg;
            end else if (a == `OFS_SENSOR_BITS) begin
                pick_word = sensor_reg;
            end else if (a == `OFS_UP_REL_ECHO) begin
                pick_word = up_echo_reg;
            end else if (a == `OFS_REV_TAG_LO) begin
                pick_word = rev_lo_reg;
            end else if (a == `OFS_REV_TAG_HI) begin
                pick_word = rev_hi_reg;
            end else if (a == `OFS_DN_REL_ECHO) begin
                pick_word = dn_echo_reg;
            end else if (a == `OFS_DN_HELD_TAG_HI) begin
                pick_word = held_hi_reg;
            end else if (a == `OFS_FWD_TAG_LO) begin
                pick_word = fwd_lo_reg;
            end else if (a == `OFS_FWD_TAG_HI) begin
                pick_word = fwd_hi_reg;
            end else begin
                // Unmapped index reads zero
                pick_word = `RST_WORD;
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Heartbeat source
    heartbeat_gen #(
        .HALF_CYCLES(HB_HALF)
    ) u_beat (
        .clk(clk),
        .sys_rst(sys_rst),
        .beat(beat)
    );

    ////////////////////////////////////////////////////////////////////////
    // Two-stage synchronisers for pins and stop causes
    always @(posedge clk) begin
        if (sys_rst) begin
            pin_s1_reg <= 4'h0;
            pin_s2_reg <= 4'h0;
            stp_s1_reg <= 4'h0;
            stp_s2_reg <= 4'h0;
        end else begin
            pin_s1_reg <= {right_sensor_pin, left_sensor_pin, right_aux_pin, left_aux_pin};
            pin_s2_reg <= pin_s1_reg;
            stp_s1_reg <= {stop_ctrl_cmd, stop_ctrl_lost, stop_link_lost, stop_group};
            stp_s2_reg <= stp_s1_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Tracking words and release echoes
    always @(posedge clk) begin
        if (sys_rst) begin
            held_hi_reg <= `RST_WORD;
            fwd_lo_reg <= `RST_WORD;
            fwd_hi_reg <= `RST_WORD;
            rev_lo_reg <= `RST_WORD;
            rev_hi_reg <= `RST_WORD;
            up_echo_reg <= `RST_WORD;
            dn_echo_reg <= `RST_WORD;
        end else begin
            if (dn_zone_held) begin
                held_hi_reg <= dn_tag_hi;
            end else begin
                // No load held: word clears
                held_hi_reg <= `RST_WORD;
            end
            up_echo_reg <= up_release_out;
            dn_echo_reg <= dn_release_out;
            if (discharge_evt && !dir_reverse) begin
                fwd_lo_reg <= dn_tag_lo;
                fwd_hi_reg <= dn_tag_hi;
            end
            if (discharge_evt && dir_reverse) begin
                rev_lo_reg <= dn_tag_lo;
                rev_hi_reg <= dn_tag_hi;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sensor and stop status images
    always @(posedge clk) begin
        if (sys_rst) begin
            sensor_reg <= `RST_WORD;
            stop_reg <= `RST_WORD;
        end else begin
            sensor_reg <= `RST_WORD;
            sensor_reg[`SNS_LEFT_AUX] <= pin_s2_reg[0];
            sensor_reg[`SNS_RIGHT_AUX] <= pin_s2_reg[1];
            sensor_reg[`SNS_LEFT_SIG] <= pin_s2_reg[2] ^ left_sensor_inv;
            sensor_reg[`SNS_RIGHT_SIG] <= pin_s2_reg[3] ^ right_sensor_inv;
            sensor_reg[`SNS_HEARTBEAT] <= beat;
            stop_reg <= `RST_WORD;
            stop_reg[`STP_GROUP] <= stp_s2_reg[0];
            stop_reg[`STP_LINK_LOST] <= stp_s2_reg[1];
            stop_reg[`STP_CTRL_LOST] <= stp_s2_reg[2];
            stop_reg[`STP_CTRL_CMD] <= stp_s2_reg[3];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Zone status clamp
    always @* begin
        if (zone_state >= `ZS_MIN && zone_state <= `ZS_MAX) begin
            zs_low = {5'h00, zone_state};
        end else begin
            zs_low = `ZS_MIN;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read muxes
    always @* begin
        rdata_next = pick_word(reg_addr);
        case (img_byte_idx[3:1])
            3'h0: img_word = held_hi_reg;
            3'h1: img_word = up_echo_reg;
            3'h2: img_word = dn_echo_reg;
            3'h3: img_word = fwd_lo_reg;
            3'h4: img_word = fwd_hi_reg;
            3'h5: img_word = rev_lo_reg;
            3'h6: img_word = rev_hi_reg;
            default: img_word = sensor_reg;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered outputs
    always @(posedge clk) begin
        if (sys_rst) begin
            reg_rdata <= `RST_WORD;
            reg_ack <= 1'b0;
            img_byte <= 8'h00;
            zone_status <= `RST_WORD;
        end else begin
            reg_ack <= reg_rd | reg_wr;
            if (reg_rd) begin
                reg_rdata <= rdata_next;
            end
            if (img_byte_idx[0] == 1'b0) begin
                img_byte <= img_word[15:8];
            end else begin
                img_byte <= img_word[7:0];
            end
            zone_status <= {zone_rev_state, zs_low};
        end
    end

endmodule

// ### plc_poll_model.sv
// Controller side: polls registers, masks the zone status high byte
module plc_poll_model (
    input wire clk, // Clock
    input wire [15:0] reg_rdata, // Read data
    input wire reg_ack, // Answer
    input wire [15:0] zone_status, // Zone status word
    output logic reg_rd = 1'b0, // Read strobe
    output logic reg_wr = 1'b0, // Write strobe
    output logic [7:0] reg_addr = 8'h00, // Index
    output logic [15:0] reg_wdata = 16'h0000, // Write data
    output logic [7:0] zone_low // Masked zone status
);
    timeunit 1ns;
    timeprecision 1ns;
    assign zone_low = zone_status[7:0];
    // One strobe cycle, answer taken one edge later
    task automatic access(input logic wr, input logic [7:0] a, input logic [15:0] wd,
        output logic [15:0] d, output logic ack);
        @(posedge clk);
        reg_rd <= !wr;
        reg_wr <= wr;
        reg_addr <= a;
        reg_wdata <= wd;
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_wr <= 1'b0;
        #1;
        d = reg_rdata;
        ack = reg_ack;
    endtask
endmodule

// ### zone_input_status_registers_assertions.sv
`include "zone_input_consts.vh"
module zone_input_checker (
    input wire clk, // Clock
    input wire sys_rst, // Reset
    input wire [7:0] reg_addr, // Index
    input wire reg_rd, // Read
    input wire reg_wr, // Write
    input wire [15:0] reg_rdata, // Read data
    input wire reg_ack, // Answer
    input wire [3:0] img_byte_idx, // Byte index
    input wire [7:0] img_byte, // Image byte
    input wire dn_zone_held, // Load held
    input wire [15:0] dn_tag_hi, // Tag word 2
    input wire [15:0] dn_tag_lo, // Tag word 1
    input wire [15:0] up_release_out, // Upstream release
    input wire [15:0] dn_release_out, // Downstream release
    input wire discharge_evt, // Discharge pulse
    input wire dir_reverse, // Reverse running
    input wire [2:0] zone_state, // Zone state
    input wire [7:0] zone_rev_state, // Reversing state
    input wire [15:0] zone_status // Status word
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic [15:0] fwd_lo_q; // Shadow of forward word 1
    logic [15:0] rev_hi_q; // Shadow of reverse word 2
    // Shadow latches of the discharge words
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fwd_lo_q <= 16'h0000;
            rev_hi_q <= 16'h0000;
        end else if (discharge_evt) begin
            fwd_lo_q <= dir_reverse ? fwd_lo_q : dn_tag_lo;
            rev_hi_q <= dir_reverse ? dn_tag_hi : rev_hi_q;
        end
    end
    sequence rd_at(logic [7:0] a);
        reg_rd && reg_addr == a;
    endsequence
    sequence steady_rd(logic [7:0] a, logic s);
        rd_at(a) ##0 (s && !$past(sys_rst));
    endsequence
    ////////////////////////////////////////////////////////////////////////
    a_ack_follows: assert property ((reg_rd || reg_wr) |=> reg_ack)
        else $error("No answer after request");
    a_ack_unasked: assert property (!reg_rd && !reg_wr |=> !reg_ack)
        else $error("Answer without request");
    a_held_word: assert property (steady_rd(`OFS_DN_HELD_TAG_HI, $stable(dn_zone_held)
        && $stable(dn_tag_hi)) |=> reg_rdata == ($past(dn_zone_held) ? $past(dn_tag_hi) : 16'h0000))
        else $error("Held tracking word wrong");
    a_up_echo: assert property (steady_rd(`OFS_UP_REL_ECHO, $stable(up_release_out))
        |=> reg_rdata == $past(up_release_out)) else $error("Upstream echo wrong");
    a_dn_echo: assert property (steady_rd(`OFS_DN_REL_ECHO, $stable(dn_release_out))
        |=> reg_rdata == $past(dn_release_out)) else $error("Downstream echo wrong");
    a_fwd_latch: assert property (rd_at(`OFS_FWD_TAG_LO) |=> reg_rdata == $past(fwd_lo_q))
        else $error("Forward word wrong");
    a_rev_latch: assert property (rd_at(`OFS_REV_TAG_HI) |=> reg_rdata == $past(rev_hi_q))
        else $error("Reverse word wrong");
    a_stop_reserved: assert property (rd_at(`OFS_STOP_STATUS) |=> (reg_rdata & 16'hFA1F) == 0)
        else $error("Reserved stop bit set");
    a_zone_code: assert property (zone_state inside {[1:6]} |=> zone_status ==
        {$past(zone_rev_state), 5'h00, $past(zone_state)}) else $error("Zone status wrong");
    a_zone_clamp: assert property (!(zone_state inside {[1:6]}) |=> zone_status[7:0] == 8'h01)
        else $error("Illegal zone state not clamped");
    a_image_order: assert property (img_byte_idx == 4'h2 && $stable(up_release_out)
        && !$past(sys_rst) |=> img_byte == 8'($past(up_release_out) >> 8))
        else $error("Image byte order wrong");
endmodule
bind zone_input_status_registers zone_input_checker zone_input_checker_i (.clk(clk),
    .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_rdata(reg_rdata), .reg_ack(reg_ack), .img_byte_idx(img_byte_idx),
    .img_byte(img_byte), .dn_zone_held(dn_zone_held), .dn_tag_hi(dn_tag_hi),
    .dn_tag_lo(dn_tag_lo), .up_release_out(up_release_out), .dn_release_out(dn_release_out),
    .discharge_evt(discharge_evt), .dir_reverse(dir_reverse), .zone_state(zone_state),
    .zone_rev_state(zone_rev_state), .zone_status(zone_status));

// ### zone_input_status_registers_bench.sv
`include "zone_input_consts.vh"
module zone_input_status_registers_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, sys_rst = 1, held = 0, evt = 0, rev = 0; // Control levels
    logic [3:0] pin_v = 0, stop_v = 0, idx = 0; // Pins, stop causes, byte index
    logic [1:0] inv_v = 0; // Sensor polarity
    logic [15:0] thi = 0, tlo = 0, up_rel = 0, dn_rel = 0; // Words in
    logic [2:0] zs = 1; // Zone state
    logic [7:0] zr = 0; // Reversing state
    wire rd, wr, ack; // Bus strobes
    wire [7:0] addr, ibyte, zlow; // Bus index, image byte, masked status
    wire [15:0] wdata, rdata, zstat; // Bus words
    int bad_count = 0, comparisons = 0; // Tallies
    always #25 clk = ~clk;
    zone_input_status_registers #(.HB_HALF(8)) zone_input_status_registers_i (.clk(clk),
        .sys_rst(sys_rst), .reg_addr(addr), .reg_rd(rd), .reg_wr(wr), .reg_wdata(wdata),
        .reg_rdata(rdata), .reg_ack(ack), .img_byte_idx(idx), .img_byte(ibyte),
        .dn_zone_held(held), .dn_tag_hi(thi), .dn_tag_lo(tlo), .up_release_out(up_rel),
        .dn_release_out(dn_rel), .discharge_evt(evt), .dir_reverse(rev),
        .left_aux_pin(pin_v[0]), .right_aux_pin(pin_v[1]), .left_sensor_pin(pin_v[2]),
        .right_sensor_pin(pin_v[3]), .left_sensor_inv(inv_v[0]), .right_sensor_inv(inv_v[1]),
        .stop_group(stop_v[0]), .stop_link_lost(stop_v[1]), .stop_ctrl_lost(stop_v[2]),
        .stop_ctrl_cmd(stop_v[3]), .zone_state(zs), .zone_rev_state(zr), .zone_status(zstat));
    plc_poll_model plc_poll_model_i (.clk(clk), .reg_rdata(rdata), .reg_ack(ack),
        .zone_status(zstat), .reg_rd(rd), .reg_wr(wr), .reg_addr(addr), .reg_wdata(wdata),
        .zone_low(zlow));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] wd,
        output logic [15:0] d);
        logic k;
        plc_poll_model_i.access(w, a, wd, d, k);
        check({15'h0000, k}, 16'h0001);
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_echo_held;
        logic [15:0] d;
        logic [15:0] w [3];
        w = '{16'hBEEF, 16'hA55A, 16'h1234};
        up_rel <= w[1];
        dn_rel <= w[2];
        held <= 1'b1;
        thi <= w[0];
        wait_n(3);
        xfer(1'b1, `OFS_UP_REL_ECHO, 16'hFFFF, d);
        xfer(1'b0, `OFS_UP_REL_ECHO, 16'h0000, d);
        check(d, w[1]);
        xfer(1'b0, `OFS_DN_REL_ECHO, 16'h0000, d);
        check(d, w[2]);
        xfer(1'b0, 8'h00, 16'h0000, d);
        check(d, 16'h0000);
        xfer(1'b0, `OFS_DN_HELD_TAG_HI, 16'h0000, d);
        check(d, w[0]);
        for (int i = 0; i < 6; i++) begin
            idx <= 4'(i);
            wait_n(2);
            #1 check({8'h00, ibyte}, {8'h00, i[0] ? w[i/2][7:0] : w[i/2][15:8]});
        end
        held <= 1'b0;
        wait_n(2);
        xfer(1'b0, `OFS_DN_HELD_TAG_HI, 16'h0000, d);
        check(d, 16'h0000);
        $display("Echo and held test done");
    endtask
    task automatic t_discharge;
        logic [15:0] d;
        logic [7:0] a [4];
        logic [15:0] e [4];
        a = '{`OFS_FWD_TAG_LO, `OFS_FWD_TAG_HI, `OFS_REV_TAG_LO, `OFS_REV_TAG_HI};
        e = '{16'h1111, 16'h2222, 16'h3333, 16'h4444};
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            tlo <= e[2 * k];
            thi <= e[2 * k + 1];
            rev <= k[0];
            evt <= 1'b1;
            @(posedge clk);
            evt <= 1'b0;
        end
        for (int i = 0; i < 4; i++) begin
            xfer(1'b0, a[i], 16'h0000, d);
            check(d, e[i]);
        end
        $display("Discharge test done");
    endtask
    task automatic t_sensor;
        logic [15:0] d;
        int hi;
        logic [5:0] p [3];
        p = '{6'b001011, 6'b011100, 6'b110000};
        for (int i = 0; i < 3; i++) begin
            {inv_v, pin_v} <= p[i];
            wait_n(5);
            xfer(1'b0, `OFS_SENSOR_BITS, 16'h0000, d);
            check(d & 16'h7FFF, {9'h000, p[i][3] ^ p[i][5], 1'b0, p[i][2] ^ p[i][4],
                1'b0, p[i][1], 1'b0, p[i][0]});
        end
        hi = 0;
        for (int i = 0; i < 16; i++) begin
            xfer(1'b0, `OFS_SENSOR_BITS, 16'h0000, d);
            hi += (d[15] === 1'b1);
        end
        check(16'(hi), 16'h0008);
        $display("Sensor test done");
    endtask
    task automatic t_stop_zone;
        logic [15:0] d;
        int b [4];
        b = '{5, 6, 7, 10};
        for (int k = 0; k < 5; k++) begin
            stop_v <= (k < 4) ? 4'(1 << k) : 4'hF;
            wait_n(5);
            xfer(1'b0, `OFS_STOP_STATUS, 16'h0000, d);
            check(d, (k < 4) ? 16'(1 << b[k]) : 16'h04E0);
        end
        for (int s = 1; s < 7; s++) begin
            zs <= 3'(s);
            zr <= 8'(8'h80 + s);
            wait_n(2);
            #1 check(zstat, {8'(8'h80 + s), 8'(s)});
            check({8'h00, zlow}, 16'(s));
        end
        for (int s = 0; s < 2; s++) begin
            zs <= s[0] ? 3'h7 : 3'h0;
            wait_n(2);
            #1 check({8'h00, zstat[7:0]}, 16'h0001);
        end
        $display("Stop and zone test done");
    endtask
    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        wait_n(8);
        sys_rst <= 1'b0;
        t_echo_held();
        t_discharge();
        t_sensor();
        t_stop_zone();
        tally_and_finish();
    end
    initial begin
        #(5000 * 50);
        bad_count++;
        tally_and_finish();
    end
endmodule
